// ===== blpd_params.svh
// Constants for the brightness limit preset and disable block
`ifndef BLPD_PARAMS_SVH
`define BLPD_PARAMS_SVH
// ==========================================================
// Register byte offsets
`define BLPD_OFS_CTRL      8'h00
`define BLPD_OFS_STATUS    8'h04
`define BLPD_OFS_DELAY     8'h08
`define BLPD_OFS_CH_BASE   8'h10
`define BLPD_OFS_CH_CFG    4'h0
`define BLPD_OFS_CH_HYST   4'h4
`define BLPD_OFS_CH_EFF    4'h8
`define BLPD_OFS_CH_LOWER  4'hC
// ==========================================================
// Control register fields
`define BLPD_CTRL_USE      0
`define BLPD_CTRL_POL      1
`define BLPD_CTRL_RET_LO   2
`define BLPD_CTRL_DL       4
// ==========================================================
// Channel configuration fields
`define BLPD_CFG_UPPER     16
`define BLPD_CFG_FB_EN     17
`define BLPD_CFG_FB_ACT    18
`define BLPD_CFG_TEACH_LO  19
`define BLPD_CFG_OVWR      21
// ==========================================================
// Reset values
`define BLPD_RST_CTRL      8'h00
`define BLPD_RST_CFG       22'h01_0000
`define BLPD_RST_HYST      27'h000_0000
`define BLPD_RST_DELAY     32'h0000_0000
`endif

// ===== blpd_pkg.sv
// Types shared by the brightness limit preset and disable block
package blpd_pkg;
   // ========================================================
   // Bus voltage state, Gray coded along fail, wait, online
   typedef enum logic [1:0] {
      BLPD_OFFLINE  = 2'b00,
      BLPD_RET_WAIT = 2'b01,
      BLPD_ONLINE   = 2'b11
   } blpd_bus_t;
   // ========================================================
   // Return behaviour of the disable function
   typedef enum logic [1:0] {
      BLPD_RET_OFF     = 2'b00,
      BLPD_RET_ON      = 2'b01,
      BLPD_RET_RESTORE = 2'b10
   } blpd_ret_t;
   // ========================================================
   // Whole block state
   typedef struct packed {
      blpd_bus_t          bus;
      logic [31:0]        ret_cnt;
      logic               dis;
      logic               saved_dis;
      logic [7:0]         ctrl;
      logic [31:0]        delay;
      logic [2:0][21:0]   cfg;
      logic [2:0][26:0]   hyst;
      logic [2:0]         ext_set;
      logic [2:0][15:0]   ext_code;
      logic [2:0][15:0]   eff;
      logic [2:0][26:0]   upper;
      logic [2:0][26:0]   lower;
      logic [2:0]         fb_tx;
      logic [2:0]         fb_rsp;
      logic               eval_start;
      logic               aw_ok;
      logic [7:0]         aw_addr;
      logic               w_ok;
      logic [31:0]        w_data;
      logic [3:0]         w_strb;
      logic               bvalid;
      logic [1:0]         bresp;
      logic               rvalid;
      logic [31:0]        rdata;
      logic [1:0]         rresp;
   } blpd_state_t;
endpackage : blpd_pkg

// ===== blpd_top.sv
// Brightness limit preset, teach, feedback and disable control
// Overview of operation
// - Preset telegram replaces the limit, as lux float
// - New limit recomputes both thresholds from hysteresis
// - Preset or taught limit holds until next preset, teach or download with overwrite
// - Active feedback sends on change, download, delayed return
// - Passive feedback only answers read requests
// - Teach-active captures present brightness as limit
// - Opposite teach value reverts to configured limit
// - Teach on both polarities always captures
// - Teach overwrites an earlier preset
// - Every teach-active telegram captures afresh
// - Download with overwrite restores configured limit
// - Configured limit applies until first preset or teach
// - Presets and taught limits survive bus failure
// - Presets and teach also work while disabled
// - While disabled, no evaluation and no output telegrams; active feedback on fb_send and read answers still go out
// - Disable input sets disable with configured polarity
// - Return mode off: evaluate and send at once
// - Return mode on: start disabled after return
// - Return mode restore: reapply disable saved at failure
// - Download starts evaluation or holds disabled, as set
// - Upper type: lower = limit - hyst; else upper = + hyst
// - Three independent limits with own objects
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`include "blpd_params.svh"
`timescale 1ns/1ps
`default_nettype none
module blpd_top
   import blpd_pkg::*;
(
   // Clock, reset and enable
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          ce,
   // AXI4-Lite write address
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [7:0]    s_axi_awaddr,
   // AXI4-Lite write data
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   // AXI4-Lite write response
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   output logic [1:0]         s_axi_bresp,
   // AXI4-Lite read address
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   input  wire logic [7:0]    s_axi_araddr,
   // AXI4-Lite read data
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   // Telegram events from the bus transport
   input  wire logic [2:0]    preset_wr,
   input  wire logic [47:0]   preset_code,
   input  wire logic [2:0]    teach_wr,
   input  wire logic [2:0]    teach_bit,
   input  wire logic [2:0]    fb_read,
   input  wire logic          disable_wr,
   input  wire logic          disable_bit,
   // Device events
   input  wire logic          bus_fail,
   input  wire logic          bus_return,
   input  wire logic          download_done,
   // Measured brightness, lux float code
   input  wire logic [15:0]   brightness,
   // Limit evaluation outputs
   output logic               eval_enable,
   output logic               eval_start,
   output logic [80:0]        upper_thr,
   output logic [80:0]        lower_thr,
   // Feedback outputs
   output logic [47:0]        eff_value,
   output logic [2:0]         fb_send,
   output logic [2:0]         fb_answer
);

   // ========================================================
   // Helper functions

   // Lux float code to magnitude in 0.01 lux, negatives to zero
   function automatic logic [26:0] blpd_mag(input logic [15:0] c);
      logic [26:0] m;
      m = {16'h0000, c[10:0]};
      if (c[15]) begin
         blpd_mag = 27'h000_0000;
      end else begin
         blpd_mag = m << c[14:11];
      end
   endfunction : blpd_mag

   // Byte-lane merge of a write into a stored word
   function automatic logic [31:0] blpd_merge(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      blpd_merge = r;
   endfunction : blpd_merge

   // Channel index of a byte address, 3 when not a channel
   function automatic logic [1:0] blpd_chan(input logic [7:0] a);
      if (a[7:6] == 2'b00 && a[5:4] != 2'b00) begin
         blpd_chan = a[5:4] - 2'b01;
      end else begin
         blpd_chan = 2'b11;
      end
   endfunction : blpd_chan

   // ========================================================
   // State and its next value
   blpd_state_t st_reg;
   blpd_state_t st_next;

   // ========================================================
   // Handshake outputs
   assign s_axi_awready = ~st_reg.aw_ok & ~st_reg.bvalid;
   assign s_axi_wready  = ~st_reg.w_ok & ~st_reg.bvalid;
   assign s_axi_arready = ~st_reg.rvalid;

   // Registered outputs
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp  = st_reg.bresp;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata  = st_reg.rdata;
   assign s_axi_rresp  = st_reg.rresp;
   assign eval_start   = st_reg.eval_start;
   assign upper_thr    = st_reg.upper;
   assign lower_thr    = st_reg.lower;
   assign eff_value    = st_reg.eff;
   assign fb_send      = st_reg.fb_tx;
   assign fb_answer    = st_reg.fb_rsp;

   // Limit evaluation runs only with bus up and not disabled; disable counts only while the ctrl use bit is set
   assign eval_enable  = (st_reg.bus != BLPD_OFFLINE)
                         & ~(st_reg.dis & st_reg.ctrl[`BLPD_CTRL_USE]);

   // ========================================================
   // Next-state logic
   always_comb begin
      logic [1:0]  ch;
      logic [31:0] w;
      logic [26:0] mg;
      logic [15:0] nv;
      logic        act;
      logic        dl_fb;
      logic        ret_fb;
      logic        was_dis;
      blpd_ret_t   rm;
      ch      = 2'b11;
      w       = 32'h0000_0000;
      mg      = 27'h000_0000;
      nv      = 16'h0000;
      act     = 1'b0;
      dl_fb   = 1'b0;
      ret_fb  = 1'b0;
      was_dis = 1'b0;
      rm      = blpd_ret_t'(st_reg.ctrl[`BLPD_CTRL_RET_LO +: 2]);
      st_next = st_reg;
      st_next.fb_tx      = 3'b000;
      st_next.fb_rsp     = 3'b000;
      st_next.eval_start = 1'b0;

      // Write address and data are taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         st_next.aw_ok   = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_next.w_ok   = 1'b1;
         st_next.w_data = s_axi_wdata;
         st_next.w_strb = s_axi_wstrb;
      end

      // Register write once both halves are present
      if (st_reg.aw_ok && st_reg.w_ok) begin
         st_next.aw_ok  = 1'b0;
         st_next.w_ok   = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp  = 2'b00;
         ch = blpd_chan(st_reg.aw_addr);
         if (st_reg.aw_addr == `BLPD_OFS_CTRL) begin
            w = blpd_merge({24'h00_0000, st_reg.ctrl},
                           st_reg.w_data, st_reg.w_strb);
            st_next.ctrl = w[7:0];
         end else if (st_reg.aw_addr == `BLPD_OFS_DELAY) begin
            st_next.delay = blpd_merge(st_reg.delay,
                                       st_reg.w_data, st_reg.w_strb);
         end else if (st_reg.aw_addr == `BLPD_OFS_STATUS) begin
            st_next.bresp = 2'b00;
         end else if (ch != 2'b11 &&
                      st_reg.aw_addr[3:0] == `BLPD_OFS_CH_CFG) begin
            w = blpd_merge({10'h000, st_reg.cfg[ch]},
                           st_reg.w_data, st_reg.w_strb);
            st_next.cfg[ch] = w[21:0];
         end else if (ch != 2'b11 &&
                      st_reg.aw_addr[3:0] == `BLPD_OFS_CH_HYST) begin
            w = blpd_merge({5'h00, st_reg.hyst[ch]},
                           st_reg.w_data, st_reg.w_strb);
            st_next.hyst[ch] = w[26:0];
         end else if (ch != 2'b11 &&
                      (st_reg.aw_addr[3:0] == `BLPD_OFS_CH_EFF ||
                       st_reg.aw_addr[3:0] == `BLPD_OFS_CH_LOWER)) begin
            st_next.bresp = 2'b00;
         end else begin
            st_next.bresp = 2'b10;
         end
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end

      // Register read
      if (s_axi_arvalid && s_axi_arready) begin
         st_next.rvalid = 1'b1;
         st_next.rresp  = 2'b00;
         st_next.rdata  = 32'h0000_0000;
         ch = blpd_chan(s_axi_araddr);
         if (s_axi_araddr == `BLPD_OFS_CTRL) begin
            st_next.rdata = {24'h00_0000, st_reg.ctrl};
         end else if (s_axi_araddr == `BLPD_OFS_STATUS) begin
            st_next.rdata = {25'h000_0000, st_reg.ext_set,
                             st_reg.bus, st_reg.dis, eval_enable};
         end else if (s_axi_araddr == `BLPD_OFS_DELAY) begin
            st_next.rdata = st_reg.delay;
         end else if (ch == 2'b11) begin
            st_next.rresp = 2'b10;
         end else begin
            unique case (s_axi_araddr[3:0])
               `BLPD_OFS_CH_CFG: begin
                  st_next.rdata = {10'h000, st_reg.cfg[ch]};
               end
               `BLPD_OFS_CH_HYST: begin
                  st_next.rdata = {5'h00, st_reg.hyst[ch]};
               end
               `BLPD_OFS_CH_EFF: begin
                  st_next.rdata = {16'h0000, st_reg.eff[ch]};
               end
               `BLPD_OFS_CH_LOWER: begin
                  st_next.rdata = {5'h00, st_reg.lower[ch]};
               end
               default: begin
                  st_next.rresp = 2'b10;
               end
            endcase
         end
      end
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end

      // Disable input telegram, ignored while the bus is down
      if (disable_wr && st_reg.bus != BLPD_OFFLINE) begin
         st_next.dis = (disable_bit == st_reg.ctrl[`BLPD_CTRL_POL]);
      end

      // Bus voltage supervision
      unique case (st_reg.bus)
         BLPD_ONLINE: begin
            if (bus_fail) begin
               st_next.bus       = BLPD_OFFLINE;
               st_next.saved_dis = st_reg.dis;
            end
         end
         BLPD_RET_WAIT: begin
            if (bus_fail) begin
               st_next.bus       = BLPD_OFFLINE;
               st_next.saved_dis = st_reg.dis;
            end else if (st_reg.ret_cnt == 32'h0000_0000) begin
               st_next.bus = BLPD_ONLINE;
               ret_fb      = 1'b1;
            end else begin
               st_next.ret_cnt = st_reg.ret_cnt - 32'h0000_0001;
            end
         end
         BLPD_OFFLINE: begin
            if (bus_return) begin
               st_next.bus     = BLPD_RET_WAIT;
               st_next.ret_cnt = st_reg.delay;
               if (rm == BLPD_RET_ON) begin
                  st_next.dis = 1'b1;
               end else if (rm == BLPD_RET_RESTORE) begin
                  st_next.dis = st_reg.saved_dis;
               end else begin
                  st_next.dis = 1'b0;
               end
               was_dis = st_next.dis & st_reg.ctrl[`BLPD_CTRL_USE];
               st_next.eval_start = ~was_dis;
            end
         end
         default: begin
            st_next.bus = BLPD_OFFLINE;
         end
      endcase

      // Configuration download sets the disable state
      if (download_done) begin
         st_next.dis = st_reg.ctrl[`BLPD_CTRL_DL];
         was_dis = st_reg.ctrl[`BLPD_CTRL_DL] &
                   st_reg.ctrl[`BLPD_CTRL_USE];
         st_next.eval_start = ~was_dis & (st_reg.bus != BLPD_OFFLINE);
         dl_fb = 1'b1;
      end

      // Per-channel limit handling, independent of disable
      for (int i = 0; i < 3; i++) begin
         if (download_done && st_reg.cfg[i][`BLPD_CFG_OVWR]) begin
            st_next.ext_set[i] = 1'b0;
         end
         if (preset_wr[i]) begin
            st_next.ext_set[i]  = 1'b1;
            st_next.ext_code[i] = preset_code[i*16 +: 16];
         end
         if (teach_wr[i]) begin
            act = st_reg.cfg[i][`BLPD_CFG_TEACH_LO + 1] |
                  (teach_bit[i] != st_reg.cfg[i][`BLPD_CFG_TEACH_LO]);
            if (act) begin
               st_next.ext_set[i]  = 1'b1;
               st_next.ext_code[i] = brightness;
            end else begin
               st_next.ext_set[i] = 1'b0;
            end
         end
         // Configured limit until a first preset or teach
         nv = st_next.ext_set[i] ? st_next.ext_code[i]
                                 : st_next.cfg[i][15:0];
         st_next.eff[i] = nv;
         // Both thresholds are derived in the same update
         mg = blpd_mag(nv);
         if (st_next.cfg[i][`BLPD_CFG_UPPER]) begin
            st_next.upper[i] = mg;
            st_next.lower[i] = (mg > st_next.hyst[i])
                               ? mg - st_next.hyst[i]
                               : 27'h000_0000;
         end else begin
            st_next.lower[i] = mg;
            st_next.upper[i] = (mg > ~st_next.hyst[i])
                               ? 27'h7FF_FFFF
                               : mg + st_next.hyst[i];
         end
         // Active feedback on change, download and return
         if (st_reg.cfg[i][`BLPD_CFG_FB_EN] &&
             st_reg.cfg[i][`BLPD_CFG_FB_ACT] &&
             st_next.bus != BLPD_OFFLINE) begin
            st_next.fb_tx[i] = (nv != st_reg.eff[i]) | dl_fb | ret_fb;
         end
         // Read requests are answered in both feedback modes
         if (fb_read[i] && st_reg.cfg[i][`BLPD_CFG_FB_EN] &&
             st_reg.bus != BLPD_OFFLINE) begin
            st_next.fb_rsp[i] = 1'b1;
         end
      end
   end

   // ========================================================
   // State register with synchronous reset and clock enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg          <= '0;
         st_reg.bus      <= BLPD_ONLINE;
         st_reg.ctrl     <= `BLPD_RST_CTRL;
         st_reg.delay    <= `BLPD_RST_DELAY;
         st_reg.cfg      <= {3{`BLPD_RST_CFG}};
         st_reg.hyst     <= {3{`BLPD_RST_HYST}};
         st_reg.upper    <= '0;
         st_reg.lower    <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

endmodule : blpd_top
`default_nettype wire

// ===== blpd_sva.sv
// Assertion checker for the brightness limit preset and disable block
`timescale 1ns/1ps
`default_nettype none
module blpd_sva
   import blpd_pkg::*;
(
   // Clock, reset and enable
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        ce,
   // Register bus handshakes
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   // Telegram events
   input wire logic [2:0]  preset_wr,
   input wire logic [47:0] preset_code,
   input wire logic [2:0]  teach_wr,
   input wire logic [2:0]  fb_read,
   input wire logic        bus_fail,
   input wire logic        download_done,
   // Evaluation and feedback outputs
   input wire logic        eval_enable,
   input wire logic        eval_start,
   input wire logic [80:0] upper_thr,
   input wire logic [80:0] lower_thr,
   input wire logic [47:0] eff_value,
   input wire logic [2:0]  fb_answer
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Magnitude of a lux float code, negative reads as zero
   function automatic logic [26:0] mag(input logic [15:0] c);
      return c[15] ? 27'h000_0000 : 27'(c[10:0]) << c[14:11];
   endfunction : mag
   // =========================================================
   // Sequences
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_preset0;
      ce && preset_wr[0] && !teach_wr[0] && !download_done;
   endsequence
   // =========================================================
   // Assertions
   wr_resp_time_a: assert property (s_wr_both |-> ##2 s_axi_bvalid)
      else $error("late write response");
   resp_stands_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid)
      else $error("bvalid dropped");
   read_gate_a: assert property (s_axi_arready != s_axi_rvalid)
      else $error("arready wrong");
   preset_load_a: assert property (
      s_preset0 |=> eff_value[15:0] == $past(preset_code[15:0]))
      else $error("preset not taken");
   preset_thr_a: assert property (
      s_preset0 |=> upper_thr[26:0] == mag($past(preset_code[15:0]))
                 || lower_thr[26:0] == mag($past(preset_code[15:0])))
      else $error("threshold not limit");
   freeze_hold_a: assert property (!ce |=> $stable(eff_value) &&
      $stable(upper_thr) && $stable(lower_thr))
      else $error("change while frozen");
   thr_order_a: assert property (
      upper_thr[26:0] >= lower_thr[26:0] &&
      upper_thr[53:27] >= lower_thr[53:27] &&
      upper_thr[80:54] >= lower_thr[80:54])
      else $error("thresholds crossed");
   read_answer_a: assert property ((fb_answer & ~$past(fb_read)) == 3'b000)
      else $error("answer without read");
   fail_stop_a: assert property (ce && bus_fail |=> !eval_enable)
      else $error("enabled after failure");
   start_gated_a: assert property (eval_start |-> eval_enable)
      else $error("start while disabled");
   dl_start_a: assert property (
      ce && download_done |=> eval_start == eval_enable)
      else $error("download start wrong");
endmodule : blpd_sva
bind blpd_top blpd_sva blpd_sva_inst (.*);
`default_nettype wire

// ===== blpd_bus_model.sv
// Telegram source standing in for the building bus transport
`timescale 1ns/1ps
`default_nettype none
module blpd_bus_model (
   // Clock
   input  wire logic       aclk,
   // Telegram events toward the block
   output var logic [2:0]  preset_wr,
   output var logic [47:0] preset_code,
   output var logic [2:0]  teach_wr,
   output var logic [2:0]  teach_bit,
   output var logic [2:0]  fb_read,
   output var logic        disable_wr,
   output var logic        disable_bit,
   output var logic        bus_fail,
   output var logic        bus_return,
   output var logic        download_done
);
   // Idle levels at time zero
   initial begin
      {preset_code, preset_wr, teach_wr, teach_bit, fb_read} = '0;
      {disable_wr, disable_bit, bus_fail, bus_return, download_done} = '0;
   end
   // One telegram: kind 0 preset, 1 teach, 2 read, 3 disable,
   // 4 fail, 5 return, other download; data lines flip when idle
   task tel(input int k, input int ch, input logic [15:0] v);
      @(posedge aclk);
      case (k)
         0: preset_code[16*ch +: 16] <= v;
         1: teach_bit[ch] <= v[0];
         3: disable_bit <= v[0];
         default: ;
      endcase
      case (k)
         0: preset_wr[ch] <= 1'b1;
         1: teach_wr[ch] <= 1'b1;
         2: fb_read[ch] <= 1'b1;
         3: disable_wr <= 1'b1;
         4: bus_fail <= 1'b1;
         5: bus_return <= 1'b1;
         default: download_done <= 1'b1;
      endcase
      @(posedge aclk);
      {preset_wr, teach_wr, fb_read, disable_wr} <= '0;
      {bus_fail, bus_return, download_done} <= '0;
      {preset_code, teach_bit} <= ~{preset_code, teach_bit};
      disable_bit <= ~disable_bit;
   endtask : tel
endmodule : blpd_bus_model
`default_nettype wire

// ===== blpd_tb.sv
// Self-checking bench for the brightness limit preset and disable block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, rd_d;
   logic [3:0]  s_axi_wstrb;
   logic [15:0] brightness, b;
   logic [1:0]  rsp;
   wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire logic   s_axi_rvalid, eval_enable, eval_start, disable_wr, disable_bit;
   wire logic   bus_fail, bus_return, download_done;
   wire logic [1:0]  s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic [80:0] upper_thr, lower_thr;
   wire logic [47:0] eff_value, preset_code;
   wire logic [2:0]  fb_send, fb_answer, preset_wr, teach_wr, teach_bit, fb_read;
   int          n_mismatch, check_count, seed, n, m, p, ch;
   logic [15:0] cfg_c [3];
   logic [15:0] eff_e [3];
   logic [26:0] hy [3];
   // =========================================================
   // Design and telegram source
   blpd_top blpd_top_inst (.*);
   blpd_bus_model blpd_bus_model_inst (.*);
   // =========================================================
   // Helpers
   function automatic logic [26:0] mag(input logic [15:0] c);
      return c[15] ? 27'h000_0000 : 27'(c[10:0]) << c[14:11];
   endfunction : mag
   function logic [15:0] rnd();
      return 16'($random(seed)) & 16'h7FFF;
   endfunction : rnd
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task chk_thr(input int c);
      logic [27:0] g, h;
      g = 28'(mag(eff_e[c]));
      h = 28'(hy[c]);
      chk(eff_value[16*c +: 16], eff_e[c]);
      chk(upper_thr[27*c +: 27], c != 1 ? g : (g + h > 28'h7FF_FFFF ?
         28'h7FF_FFFF : g + h));
      chk(lower_thr[27*c +: 27], c == 1 ? g : (g > h ? g - h : 28'h0));
   endtask : chk_thr
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ad, wd, b1;
      {ad, wd, b1} = 3'b000;
      @(posedge aclk);
      {s_axi_awvalid, s_axi_awaddr, s_axi_wvalid, s_axi_wdata, s_axi_bready}
         <= {1'b1, a, 1'b1, d, 1'b1};
      // Handshakes are judged before the edge that takes them
      while (!b1) begin
         @(negedge aclk);
         ad |= s_axi_awvalid & s_axi_awready;
         wd |= s_axi_wvalid & s_axi_wready;
         {b1, rsp} = {s_axi_bvalid, s_axi_bresp};
         @(posedge aclk);
         {s_axi_awvalid, s_axi_wvalid} <= {!ad, !wd};
      end
      s_axi_bready <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a);
      logic ad, r1;
      {ad, r1} = 2'b00;
      @(posedge aclk);
      {s_axi_arvalid, s_axi_araddr, s_axi_rready} <= {1'b1, a, 1'b1};
      while (!r1) begin
         @(negedge aclk);
         ad |= s_axi_arvalid & s_axi_arready;
         {r1, rsp, rd_d} = {s_axi_rvalid, s_axi_rresp, s_axi_rdata};
         @(posedge aclk);
         s_axi_arvalid <= !ad;
      end
      s_axi_rready <= 1'b0;
   endtask : rd
   task tx(input int k, input int c, input logic [15:0] v);
      blpd_bus_model_inst.tel(k, c, v);
      @(negedge aclk);
   endtask : tx
   task close_out();
      $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   // =========================================================
   // Clock and watchdog
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   initial begin
      #40000;
      n_mismatch++;
      close_out();
   end
   // =========================================================
   // Main sequence
   initial begin
      seed = 32'h1fd0;
      {aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'b01000;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0_0000;
      {s_axi_wdata, s_axi_wstrb, brightness} = {32'h0000_0000, 4'hF, 16'h0000};
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h10);
      chk(rd_d, 32'h0001_0000);
      rd(8'h0C);
      chk({rsp, rd_d[29:0]}, 32'h8000_0000);
      wr(8'h0C, 32'hFFFF_FFFF);
      chk(rsp, 32'h0000_0002);
      for (ch = 0; ch < 3; ch++) begin
         hy[ch] = 27'(rnd());
         cfg_c[ch] = rnd();
         eff_e[ch] = cfg_c[ch];
         wr(8'h14 + 8'(16 * ch), 32'(hy[ch]));
         wr(8'h10 + 8'(16 * ch), {13'h0000, ch != 2, 1'b1, ch != 1, cfg_c[ch]});
         @(negedge aclk);
         chk_thr(ch);
      end
      for (n = 0; n < 6; n++) begin
         ch = n % 3;
         eff_e[ch] = rnd();
         tx(0, ch, eff_e[ch]);
         chk_thr(ch);
         chk(fb_send[ch], ch != 2);
      end
      @(posedge aclk) ce <= 1'b0;
      tx(0, 0, rnd());
      chk_thr(0);
      @(posedge aclk) ce <= 1'b1;
      for (n = 0; n < 5; n++) begin
         if (n == 3)
            wr(8'h10, {10'h000, 6'b010111, cfg_c[0]});
         b = rnd();
         @(posedge aclk) brightness <= b;
         tx(1, 0, 16'(n < 2 || n == 4));
         eff_e[0] = n == 2 ? cfg_c[0] : b;
         chk_thr(0);
      end
      tx(6, 0, 0);
      chk_thr(0);
      chk(eval_start, 1);
      wr(8'h10, {10'h000, 6'b110111, cfg_c[0]});
      tx(6, 0, 0);
      eff_e[0] = cfg_c[0];
      chk_thr(0);
      tx(2, 2, 0);
      chk(fb_answer[2], 1);
      for (p = 0; p < 2; p++) begin
         wr(8'h00, 32'(1 + 2 * p));
         tx(3, 0, 16'(p));
         chk(eval_enable, 0);
         eff_e[1] = rnd();
         tx(0, 1, eff_e[1]);
         chk_thr(1);
         tx(3, 0, 16'(1 - p));
         chk(eval_enable, 1);
      end
      wr(8'h00, 32'h0000_0011);
      tx(6, 0, 0);
      chk({eval_enable, eval_start}, 0);
      tx(3, 0, 1);
      wr(8'h08, 32'h0000_0005);
      for (m = 0; m < 3; m++) begin
         wr(8'h00, 32'(3 + 4 * m));
         tx(3, 0, 16'(m == 2));
         tx(4, 0, 0);
         chk(eval_enable, 0);
         tx(5, 0, 0);
         chk({eval_start, eval_enable}, {2{m == 0}});
         for (n = 1; n < 40 && fb_send[0] !== 1'b1; n++)
            @(negedge aclk);
         chk(n, 7);
         chk_thr(0);
         tx(3, 0, 0);
      end
      close_out();
   end
endmodule : testbench
`default_nettype wire
